//--- logic/ccsb_defs.vh
// Purpose: constants of the controller cpu setup bank
// Assumes: word addresses on the register port, 16-bit data
// Notes:   included by the setup bank and its testbench
`ifndef CCSB_DEFS_VH
`define CCSB_DEFS_VH

// ----------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------
`define CCSB_A_ERR_DETECT   8'h80
`define CCSB_A_ERR_LOG      8'h81
`define CCSB_A_SCHED_UNIT   8'hc3
`define CCSB_A_INSTR_ACT    8'hc5
`define CCSB_A_BG_EXEC      8'hc6
`define CCSB_A_RETRY        8'hc8
`define CCSB_A_BLK_TMO      8'hc9
`define CCSB_A_FB_TMO       8'hca
`define CCSB_A_MIN_CYC      8'hd0
`define CCSB_A_WATCH        8'hd1
`define CCSB_A_IRQ_STATUS   8'hf0
`define CCSB_A_IRQ_MASK     8'hf1
`define CCSB_A_RUN_STATE    8'hf2

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CCSB_B_NO_BATT      15
`define CCSB_B_NO_INT_ERR   14
`define CCSB_B_NO_LOG       15
`define CCSB_B_STOP_INSTR   15
`define CCSB_B_BG_TABLE     15
`define CCSB_B_BG_STRING    14
`define CCSB_B_BG_SHIFT     13
`define CCSB_B_WATCH_USER   15
`define CCSB_F_LOW4         3:0
`define CCSB_F_UNIT         1:0
`define CCSB_F_WATCH        14:0
`define CCSB_WORD_RST       16'h0000

// interrupt status bits
`define CCSB_I_LOW_BATT     0
`define CCSB_I_INT_TASK     1
`define CCSB_I_INSTR_ERR    2
`define CCSB_I_CYC_OVER     3
`define CCSB_NIRQ           4

// scheduled interrupt unit codes
`define CCSB_UNIT_10MS      2'h0
`define CCSB_UNIT_1MS       2'h1
`define CCSB_UNIT_100US     2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CCSB_CLK_PS         8000
`define CCSB_BASE_TICK_PS   100000000
`define CCSB_MS_PER_BASE    10
`define CCSB_10MS_PER_MS    10
`define CCSB_TMO_UNIT_MS    100
`define CCSB_TMO_DEF_MS     2000
`define CCSB_WATCH_UNIT_MS  10
`define CCSB_WATCH_DEF_MS   1000

`endif

//--- logic/ccsb_tick.v
// Purpose: divider giving a one-cycle enable pulse every DIV enables
// Assumes: en is a one-cycle pulse or tied high
// Notes:   cascaded to build the slower time bases
`timescale 1ns/100ps
`default_nettype none

module ccsb_tick #(
    parameter integer DIV = 10
) (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire        clr,
    input  wire        en,
    output reg         tick
);

    reg  [31:0] cnt;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt  <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (clr) begin
            cnt  <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (en) begin
                if (cnt == DIV - 1) begin
                    cnt  <= 32'h0000_0000;
                    tick <= 1'b1;
                end else begin
                    cnt <= cnt + 32'h0000_0001;
                end
            end
        end
    end

endmodule // ccsb_tick

`default_nettype wire

//--- logic/ccsb_setup_bank.v
// Purpose: cpu setup word bank with scan supervision
// Assumes: scan and run strobes come from logic on ref_clk
// Notes:   low_batt is a pin and is synchronised here
`timescale 1ns/100ps
`default_nettype none
`include "ccsb_defs.vh"

// How it works
// - error_detect_options bit 15 mutes battery, 14 task errors, per scan.
// - instruction_error_action bit 15, latched at run start, halts on error.
// - error_log_options bit 15, read per scan, drops user faults from log.
// - background_exec_options 15..13 latch background table, string, shift.
// - background_exec_options bits 3..0 latch logical comms port, 0 to 15.
// - block_comms_retry_count bits 3..0 latch block comms retry count.
// - block_comms_timeout latches in 0.1 s units, zero means 2 s.
// - fieldbus_comms_timeout latches in 0.1 s units, zero means 2 s.
// - watch_cycle_time bit 15 picks user watch limit in 10 ms, else 1 s.
// - minimum_cycle_time latches minimum scan time in 1 ms, zero means none.
// - scheduled_interrupt_unit low field latches tick unit 10, 1, 0.1 ms.
module ccsb_setup_bank #(
    parameter integer BASE_DIV =
        `CCSB_BASE_TICK_PS / `CCSB_CLK_PS
) (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire [7:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    input  wire        run_start,
    input  wire        scan_start,
    input  wire        scan_end,
    input  wire        low_batt,
    input  wire        int_task_err,
    input  wire        instr_err,
    input  wire        user_fault,
    output reg         log_fault,
    output reg         stop_on_instr,
    output reg         bg_table,
    output reg         bg_string,
    output reg         bg_shift,
    output reg  [3:0]  comms_port,
    output reg  [3:0]  retry_count,
    output reg  [15:0] blk_timeout,
    output reg  [15:0] fb_timeout,
    output reg  [1:0]  sched_unit,
    output reg         sched_tick,
    output reg         min_time_met,
    output reg         cyc_over,
    output reg         cpu_halt,
    output reg         irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    localparam integer TMO_DEF_N = `CCSB_TMO_DEF_MS / `CCSB_TMO_UNIT_MS;
    localparam [15:0]  TMO_DEF   = TMO_DEF_N[15:0];
    localparam integer WATCH_DEF_N = `CCSB_WATCH_DEF_MS / `CCSB_WATCH_UNIT_MS;
    localparam [15:0]  WATCH_DEF   = WATCH_DEF_N[15:0];
    function [15:0] eff_tmo;
        input [15:0] w;
        begin
            eff_tmo = (w == 16'h0000) ? TMO_DEF : w;
        end
    endfunction

    // ------------------------------------------------------------
    // setup words
    // ------------------------------------------------------------
    reg  [15:0] w_detect, w_log, w_unit, w_instr, w_bg;
    reg  [15:0] w_retry, w_blk, w_fb, w_min, w_watch;
    reg  [`CCSB_NIRQ-1:0] irq_status;
    reg  [`CCSB_NIRQ-1:0] irq_mask;
    reg         in_scan;

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            w_detect <= `CCSB_WORD_RST;
            w_log    <= `CCSB_WORD_RST;
            w_unit   <= `CCSB_WORD_RST;
            w_instr  <= `CCSB_WORD_RST;
            w_bg     <= `CCSB_WORD_RST;
            w_retry  <= `CCSB_WORD_RST;
            w_blk    <= `CCSB_WORD_RST;
            w_fb     <= `CCSB_WORD_RST;
            w_min    <= `CCSB_WORD_RST;
            w_watch  <= `CCSB_WORD_RST;
            irq_mask <= {`CCSB_NIRQ{1'b0}};
        end else if (wr) begin
            if (addr == `CCSB_A_ERR_DETECT) begin
                w_detect <= wdata;
            end else if (addr == `CCSB_A_ERR_LOG) begin
                w_log <= wdata;
            end else if (addr == `CCSB_A_SCHED_UNIT) begin
                w_unit <= wdata;
            end else if (addr == `CCSB_A_INSTR_ACT) begin
                w_instr <= wdata;
            end else if (addr == `CCSB_A_BG_EXEC) begin
                w_bg <= wdata;
            end else if (addr == `CCSB_A_RETRY) begin
                w_retry <= wdata;
            end else if (addr == `CCSB_A_BLK_TMO) begin
                w_blk <= wdata;
            end else if (addr == `CCSB_A_FB_TMO) begin
                w_fb <= wdata;
            end else if (addr == `CCSB_A_MIN_CYC) begin
                w_min <= wdata;
            end else if (addr == `CCSB_A_WATCH) begin
                w_watch <= wdata;
            end else if (addr == `CCSB_A_IRQ_MASK) begin
                irq_mask <= wdata[`CCSB_NIRQ-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            if (addr == `CCSB_A_ERR_DETECT) begin
                rdata <= w_detect;
            end else if (addr == `CCSB_A_ERR_LOG) begin
                rdata <= w_log;
            end else if (addr == `CCSB_A_SCHED_UNIT) begin
                rdata <= w_unit;
            end else if (addr == `CCSB_A_INSTR_ACT) begin
                rdata <= w_instr;
            end else if (addr == `CCSB_A_BG_EXEC) begin
                rdata <= w_bg;
            end else if (addr == `CCSB_A_RETRY) begin
                rdata <= w_retry;
            end else if (addr == `CCSB_A_BLK_TMO) begin
                rdata <= w_blk;
            end else if (addr == `CCSB_A_FB_TMO) begin
                rdata <= w_fb;
            end else if (addr == `CCSB_A_MIN_CYC) begin
                rdata <= w_min;
            end else if (addr == `CCSB_A_WATCH) begin
                rdata <= w_watch;
            end else if (addr == `CCSB_A_IRQ_STATUS) begin
                rdata <= {12'h000, irq_status};
            end else if (addr == `CCSB_A_IRQ_MASK) begin
                rdata <= {12'h000, irq_mask};
            end else if (addr == `CCSB_A_RUN_STATE) begin
                rdata <= {12'h000, in_scan, min_time_met,
                          cyc_over, cpu_halt};
            end else begin
                rdata <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // per-scan sampling
    // ------------------------------------------------------------
    reg         no_batt, no_int_err, no_log;
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            no_batt    <= 1'b0;
            no_int_err <= 1'b0;
            no_log     <= 1'b0;
        end else if (scan_start) begin
            no_batt    <= w_detect[`CCSB_B_NO_BATT];
            no_int_err <= w_detect[`CCSB_B_NO_INT_ERR];
            no_log     <= w_log[`CCSB_B_NO_LOG];
        end
    end

    // ------------------------------------------------------------
    // start-of-operation latches
    // ------------------------------------------------------------
    reg  [15:0] watch_lim, min_lim;
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stop_on_instr <= 1'b0;
            bg_table      <= 1'b0;
            bg_string     <= 1'b0;
            bg_shift      <= 1'b0;
            comms_port    <= 4'h0;
            retry_count   <= 4'h0;
            blk_timeout   <= TMO_DEF;
            fb_timeout    <= TMO_DEF;
            sched_unit    <= `CCSB_UNIT_10MS;
            watch_lim     <= WATCH_DEF;
            min_lim       <= 16'h0000;
        end else if (run_start) begin
            stop_on_instr <= w_instr[`CCSB_B_STOP_INSTR];
            bg_table      <= w_bg[`CCSB_B_BG_TABLE];
            bg_string     <= w_bg[`CCSB_B_BG_STRING];
            bg_shift      <= w_bg[`CCSB_B_BG_SHIFT];
            comms_port    <= w_bg[`CCSB_F_LOW4];
            retry_count   <= w_retry[`CCSB_F_LOW4];
            blk_timeout   <= eff_tmo(w_blk);
            fb_timeout    <= eff_tmo(w_fb);
            sched_unit    <= w_unit[`CCSB_F_UNIT];
            min_lim       <= w_min;
            if (w_watch[`CCSB_B_WATCH_USER]) begin
                watch_lim <= {1'b0, w_watch[`CCSB_F_WATCH]};
            end else begin
                watch_lim <= WATCH_DEF;
            end
        end
    end

    // ------------------------------------------------------------
    // time bases: 0.1 ms, 1 ms, 10 ms
    // ------------------------------------------------------------
    wire        t_100us, t_1ms, t_10ms;
    ccsb_tick #(.DIV(BASE_DIV)) u_t100us (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .clr     (run_start),
        .en      (1'b1),
        .tick    (t_100us)
    );

    ccsb_tick #(.DIV(`CCSB_MS_PER_BASE)) u_t1ms (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .clr     (run_start),
        .en      (t_100us),
        .tick    (t_1ms)
    );

    ccsb_tick #(.DIV(`CCSB_10MS_PER_MS)) u_t10ms (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .clr     (run_start),
        .en      (t_1ms),
        .tick    (t_10ms)
    );

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sched_tick <= 1'b0;
        end else begin
            case (sched_unit)
                `CCSB_UNIT_1MS:   sched_tick <= t_1ms;
                `CCSB_UNIT_100US: sched_tick <= t_100us;
                default:          sched_tick <= t_10ms;
            endcase
        end
    end

    // ------------------------------------------------------------
    // scan supervision
    // ------------------------------------------------------------
    reg  [15:0] watch_cnt, min_cnt;
    wire        overrun;
    // the tick that carries the count past the limit is the overrun
    assign overrun = in_scan && t_10ms && !cpu_halt &&
                     (watch_cnt >= watch_lim);
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            in_scan   <= 1'b0;
            watch_cnt <= 16'h0000;
            min_cnt   <= 16'h0000;
        end else if (run_start || scan_start) begin
            in_scan   <= scan_start;
            watch_cnt <= 16'h0000;
            min_cnt   <= 16'h0000;
        end else begin
            if (scan_end) begin
                in_scan <= 1'b0;
            end
            if (in_scan && t_10ms && watch_cnt != 16'hffff) begin
                watch_cnt <= watch_cnt + 16'h0001;
            end
            if (t_1ms && min_cnt != 16'hffff) begin
                min_cnt <= min_cnt + 16'h0001;
            end
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            min_time_met <= 1'b1;
        end else if (run_start || scan_start) begin
            min_time_met <= (min_lim == 16'h0000);
        end else begin
            min_time_met <= (min_cnt >= min_lim);
        end
    end

    // ------------------------------------------------------------
    // errors and halt
    // ------------------------------------------------------------
    reg  [2:0]  batt_sync;
    reg         batt_lvl;
    wire        batt_rise, ev_batt, ev_int, ev_instr, halt_req;
    // a change counts once the second and third stages agree
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            batt_sync <= 3'h0;
            batt_lvl  <= 1'b0;
        end else begin
            batt_sync <= {batt_sync[1:0], low_batt};
            if (batt_sync[1] == batt_sync[2]) begin
                batt_lvl <= batt_sync[2];
            end
        end
    end

    assign batt_rise = batt_sync[1] && batt_sync[2] && !batt_lvl;
    assign ev_batt   = batt_rise && !no_batt;
    assign ev_int    = int_task_err && !no_int_err;
    assign ev_instr  = instr_err;
    assign halt_req  = overrun || (instr_err && stop_on_instr);

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cyc_over <= 1'b0;
            cpu_halt <= 1'b0;
        end else if (run_start) begin
            cyc_over <= 1'b0;
            cpu_halt <= 1'b0;
        end else begin
            if (overrun) begin
                cyc_over <= 1'b1;
            end
            if (halt_req) begin
                cpu_halt <= 1'b1;
            end
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            log_fault <= 1'b0;
        end else begin
            log_fault <= user_fault && !no_log;
        end
    end

    // ------------------------------------------------------------
    // interrupt status, write one to clear, set wins
    // ------------------------------------------------------------
    reg  [`CCSB_NIRQ-1:0] irq_set, irq_clr;
    always @* begin
        irq_set = {`CCSB_NIRQ{1'b0}};
        irq_set[`CCSB_I_LOW_BATT]  = ev_batt;
        irq_set[`CCSB_I_INT_TASK]  = ev_int;
        irq_set[`CCSB_I_INSTR_ERR] = ev_instr;
        irq_set[`CCSB_I_CYC_OVER]  = overrun;
        irq_clr = {`CCSB_NIRQ{1'b0}};
        if (wr && addr == `CCSB_A_IRQ_STATUS) begin
            irq_clr = wdata[`CCSB_NIRQ-1:0];
        end
    end

    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= {`CCSB_NIRQ{1'b0}};
            irq        <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
            irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
        end
    end

endmodule // ccsb_setup_bank

`default_nettype wire

//--- verif/ccsb_setup_bank_monitor.sv
// Purpose: port assertions for the cpu setup bank
// Assumes: one clock domain, nrst asynchronous and active low
// Notes:   bound to every ccsb_setup_bank instance
`timescale 1ns/100ps
`default_nettype none

module ccsb_setup_bank_monitor (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        run_start,
    input wire logic        instr_err,
    input wire logic        user_fault,
    input wire logic        log_fault,
    input wire logic        stop_on_instr,
    input wire logic        bg_table,
    input wire logic        bg_string,
    input wire logic        bg_shift,
    input wire logic [3:0]  comms_port,
    input wire logic [3:0]  retry_count,
    input wire logic [15:0] blk_timeout,
    input wire logic [15:0] fb_timeout,
    input wire logic [1:0]  sched_unit,
    input wire logic        cyc_over,
    input wire logic        cpu_halt
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // ----------------------------------------------------------------
    // halt sequences
    // ----------------------------------------------------------------
    sequence instr_stop_s;
        instr_err && stop_on_instr;
    endsequence
    sequence halt_gone_s;
        !cpu_halt && !cyc_over;
    endsequence

    cfg_hold_a: assert property (
        !run_start |=> $stable({stop_on_instr, bg_table, bg_string, bg_shift}))
        else $error("execution options changed without run start");
    field_hold_a: assert property (
        !run_start |=> $stable({comms_port, retry_count, sched_unit}))
        else $error("port, retry or unit changed without run start");
    tmo_hold_a: assert property (
        !run_start |=> $stable({blk_timeout, fb_timeout}))
        else $error("timeouts changed without run start");
    tmo_nonzero_a: assert property (
        blk_timeout != 16'h0000 && fb_timeout != 16'h0000)
        else $error("timeout output is zero");
    log_cause_a: assert property (
        log_fault |-> $past(user_fault))
        else $error("fault logged without a user fault");
    instr_halt_a: assert property (
        instr_stop_s |=> cpu_halt)
        else $error("no halt after instruction error");
    halt_hold_a: assert property (
        cpu_halt && !run_start |=> cpu_halt)
        else $error("halt dropped without run start");
    halt_clear_a: assert property (
        run_start |=> halt_gone_s)
        else $error("halt or overrun kept after run start");
    over_halt_a: assert property (
        $rose(cyc_over) |-> ##[0:1] cpu_halt)
        else $error("overrun without halt");
endmodule // ccsb_setup_bank_monitor

bind ccsb_setup_bank ccsb_setup_bank_monitor i_ccsb_setup_bank_monitor (
    .ref_clk, .nrst, .run_start, .instr_err, .user_fault, .log_fault,
    .stop_on_instr, .bg_table, .bg_string, .bg_shift, .comms_port,
    .retry_count, .blk_timeout, .fb_timeout, .sched_unit, .cyc_over,
    .cpu_halt);

`default_nettype wire

//--- verif/ccsb_setup_bank_tb.sv
// Purpose: self-checking bench for the cpu setup bank
// Assumes: short base tick divider to keep time counts small
// Notes:   word model is an int array indexed by address
`timescale 1ns/100ps
`default_nettype none
`include "ccsb_defs.vh"

module ccsb_setup_bank_tb;
    localparam int BD = 4;
    logic        ref_clk = 0, nrst = 0, wr = 0, rd = 0, low_batt = 0;
    logic [7:0]  addr = 0, ev = 0;
    logic [15:0] wdata = 0, rdata, v, blk_timeout, fb_timeout;
    logic        log_fault, stop_on_instr, bg_table, bg_string, bg_shift;
    logic        sched_tick, min_time_met, cyc_over, cpu_halt, irq;
    logic [3:0]  comms_port, retry_count;
    logic [1:0]  sched_unit;
    int          n_errors = 0, n_tests = 0, seed = 32'hb934bf00, k, n, e;
    int          w [256];
    logic [7:0]  ra [10] = '{8'h80, 8'h81, 8'hc3, 8'hc5, 8'hc6, 8'hc8,
                             8'hc9, 8'hca, 8'hd0, 8'hd1};

    ccsb_setup_bank #(.BASE_DIV(BD)) i_ccsb_setup_bank (
        .ref_clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
        .run_start(ev[0]), .scan_start(ev[1]), .scan_end(ev[2]),
        .low_batt, .int_task_err(ev[3]), .instr_err(ev[4]),
        .user_fault(ev[5]), .log_fault, .stop_on_instr, .bg_table,
        .bg_string, .bg_shift, .comms_port, .retry_count, .blk_timeout,
        .fb_timeout, .sched_unit, .sched_tick, .min_time_met, .cyc_over,
        .cpu_halt, .irq);

    always #4 ref_clk = ~ref_clk;

    // ----------------------------------------------------------------
    // bus and check tasks
    // ----------------------------------------------------------------
    task chk(input logic [15:0] s, input logic [15:0] x);
        n_tests++;
        if (s !== x) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, s, x);
        end
    endtask
    task wrr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 0;
        w[a] = d;
    endtask
    task rdr(input logic [7:0] a);
        @(posedge ref_clk);
        rd <= 1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 0;
        #1 v = rdata;
    endtask
    task pulse(input int b);
        @(posedge ref_clk);
        ev[b] <= 1;
        @(posedge ref_clk);
        ev <= 0;
    endtask
    task cyc(input int c);
        repeat (c) @(posedge ref_clk);
    endtask
    task chk_cfg;
        chk(stop_on_instr, w[8'hc5][15]);
        chk({bg_table, bg_string, bg_shift}, w[8'hc6][15:13]);
        chk(comms_port, w[8'hc6][3:0]);
        chk(retry_count, w[8'hc8][3:0]);
        chk(blk_timeout, w[8'hc9] ? w[8'hc9] : 20);
        chk(fb_timeout, w[8'hca] ? w[8'hca] : 20);
        chk(sched_unit, w[8'hc3][1:0]);
    endtask
    task give_verdict;
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        cyc(60000);
        n_errors++;
        give_verdict;
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        cyc(8);
        nrst <= 1;
        #1 chk_cfg;
        chk({min_time_met, cyc_over, cpu_halt, irq}, 4'h8);
        for (k = 0; k < 10; k++) begin
            rdr(ra[k]);
            chk(v, 0);
            n = $random(seed);
            wrr(ra[k], n[15:0]);
            rdr(ra[k]);
            chk(v, n[15:0]);
        end
        wrr(8'h7f, 16'hffff);
        rdr(8'h7f);
        chk(v, 0);
        chk(blk_timeout, 20);
        for (k = 0; k < 4; k++) begin
            wrr(8'hc5, $random(seed));
            wrr(8'hc6, $random(seed) & 16'hfff7);
            wrr(8'hc8, $random(seed));
            wrr(8'hc9, k ? $random(seed) : 0);
            wrr(8'hca, k ? $random(seed) : 0);
            wrr(8'hc3, k % 3);
            pulse(0);
            cyc(1);
            chk_cfg;
        end
        for (k = 0; k < 3; k++) begin
            wrr(8'hc3, k);
            pulse(0);
            e = 4000 / (BD * (k == 2 ? 1 : k == 1 ? 10 : 100));
            n = 0;
            repeat (4000) begin
                @(posedge ref_clk);
                #1 n += sched_tick;
            end
            chk(n >= e - 1 && n <= e + 1, 1);
        end
        // user watch limit of two 10 ms units
        wrr(8'hf1, 16'h000f);
        wrr(8'hd1, 16'h8002);
        pulse(0);
        pulse(1);
        n = 0;
        while (cyc_over !== 1'b1 && n < 3000) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(n >= 2 * 400 * BD / 4 && n <= 1300, 1);
        chk({cpu_halt, irq}, 2'b11);
        rdr(8'hf0);
        chk(v[3], 1);
        pulse(2);
        wrr(8'hd1, 16'h0000);
        pulse(0);
        wrr(8'hf0, 16'h000f);
        pulse(1);
        cyc(1300);
        chk({cyc_over, cpu_halt, irq}, 0);
        pulse(2);
        // instruction error with and without stop
        wrr(8'hc5, 16'h8000);
        wrr(8'hf1, 16'h0000);
        pulse(0);
        pulse(4);
        cyc(2);
        chk({cpu_halt, irq}, 2'b10);
        rdr(8'hf0);
        chk(v[2], 1);
        wrr(8'hf1, 16'h0004);
        cyc(2);
        chk(irq, 1);
        wrr(8'hf0, 16'h0004);
        cyc(2);
        chk(irq, 0);
        wrr(8'hc5, 16'h0000);
        pulse(0);
        pulse(4);
        cyc(2);
        chk(cpu_halt, 0);
        // low battery and task error muting
        wrr(8'hf0, 16'h000f);
        wrr(8'hf1, 16'h0003);
        wrr(8'h80, 16'hc000);
        pulse(1);
        low_batt <= 1;
        pulse(3);
        cyc(8);
        rdr(8'hf0);
        chk(v[1:0], 0);
        low_batt <= 0;
        wrr(8'h80, 16'h0000);
        pulse(1);
        cyc(8);
        low_batt <= 1;
        cyc(8);
        rdr(8'hf0);
        chk(v[1:0], 2'b01);
        pulse(3);
        cyc(1);
        rdr(8'hf0);
        chk({v[1:0], irq}, 3'b111);
        // user fault logging
        wrr(8'h81, 16'h0000);
        pulse(1);
        pulse(5);
        #1 chk(log_fault, 1);
        wrr(8'h81, 16'h8000);
        pulse(1);
        pulse(5);
        #1 chk(log_fault, 0);
        // minimum cycle time of 1 ms
        wrr(8'hd0, 16'h0001);
        pulse(0);
        pulse(1);
        cyc(1);
        #1 chk(min_time_met, 0);
        n = 0;
        while (min_time_met !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(n <= 10 * BD + 4, 1);
        // run state: in scan, minimum met, no overrun, no halt
        rdr(8'hf2);
        chk(v, 16'h000c);
        give_verdict;
    end
endmodule // ccsb_setup_bank_tb

`default_nettype wire
